// >>> pin_remap_pkg.sv
// constants for the pin remap crossbar
package pin_remap_pkg;
  // -----------------------------------------------------------
  // sizes
  // -----------------------------------------------------------
  localparam int NUM_IN = 15;
  localparam int NUM_PINS = 22;
  localparam int SEL_W = 5;
  localparam int NUM_FUNCS = 22;
  localparam logic [4:0] MAX_PIN_SEL = 5'h15;
  // -----------------------------------------------------------
  // reset values and keys
  // -----------------------------------------------------------
  localparam logic [4:0] IN_SEL_RST = 5'h1F;
  localparam logic [4:0] OUT_NULL = 5'h00;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam int LOCK_BIT_POS = 0;
  // -----------------------------------------------------------
  // input select indices
  // -----------------------------------------------------------
  localparam int IN_EXT_IRQ_ONE = 0;
  localparam int IN_EXT_IRQ_TWO = 1;
  localparam int IN_EXT_IRQ_THREE = 2;
  localparam int IN_TIMER0_CLK = 3;
  localparam int IN_TIMER3_CLK = 4;
  localparam int IN_CAPTURE_ONE = 5;
  localparam int IN_CAPTURE_TWO = 6;
  localparam int IN_TIMER1_GATE = 7;
  localparam int IN_TIMER3_GATE = 8;
  localparam int IN_SERIAL_RX = 9;
  localparam int IN_SERIAL_CLK = 10;
  localparam int IN_SPI_DATA = 11;
  localparam int IN_SPI_CLK = 12;
  localparam int IN_SPI_SEL = 13;
  localparam int IN_PWM_FAULT = 14;
  // -----------------------------------------------------------
  // output function codes
  // -----------------------------------------------------------
  localparam logic [4:0] FN_CMP1 = 5'h01;
  localparam logic [4:0] FN_CMP2 = 5'h02;
  localparam logic [4:0] FN_SER_TX = 5'h05;
  localparam logic [4:0] FN_SER_DT = 5'h06;
  localparam logic [4:0] FN_SPI_DO = 5'h09;
  localparam logic [4:0] FN_SPI_CK = 5'h0A;
  localparam logic [4:0] FN_SPI_DMA_SEL = 5'h0C;
  localparam logic [4:0] FN_WAKE = 5'h0D;
  localparam logic [4:0] FN_PWM1_A = 5'h0E;
  localparam logic [4:0] FN_PWM2_A = 5'h12;
  localparam logic [4:0] FN_PWM2_D = 5'h15;
endpackage

// >>> remappable_pin_select_lock.sv
// pin remap crossbar with lock, key sequence, one-way fuse and shadow check
//
// Functional notes
// - each peripheral input has 5-bit pin select
// - fifteen input selects for listed peripheral inputs
// - each pin has output function select
// - output code zero leaves pin disconnected
// - output codes 1,2,5,6,9,10,12,13 defined
// - codes 14-21 select two pwm units
// - output selects reset to null code
// - fan-in and fan-out allowed without lockout
// - contention between pins and outputs prevented
// - locked writes complete but change nothing
// - lock bit zero of control register
// - 55h then AAh key before lock change
// - lock holds value until changed again
// - shadow copies flag any unexpected change
// - one-way fuse keeps set lock set
// - with fuse only reset clears lock
// - fuse set allows one session; clear unlimited
// - input and output maps independent
// - input select codes past the last pin read zero
// - input selects reset to all ones
// - lock clears on every reset
`timescale 1ns/100ps
module remappable_pin_select_lock
  import pin_remap_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic one_way_lock_fuse_i,
  input wire logic in_sel_wr_i,
  input wire logic [3:0] in_sel_idx_i,
  input wire logic out_sel_wr_i,
  input wire logic [4:0] out_sel_idx_i,
  input wire logic [4:0] sel_wdata_i,
  input wire logic key_wr_i,
  input wire logic [7:0] key_wdata_i,
  input wire logic ctrl_wr_i,
  input wire logic [7:0] ctrl_wdata_i,
  input wire logic [NUM_PINS-1:0] pin_in_i,
  input wire logic [NUM_FUNCS-1:0] func_out_i,
  output logic [NUM_IN-1:0] periph_in_o,
  output logic [NUM_PINS-1:0] pin_out_o,
  output logic [NUM_PINS-1:0] pin_oe_o,
  output logic [7:0] pin_select_control_o,
  output logic map_lock_bit_o,
  output logic mismatch_reset_o
);

  // -----------------------------------------------------------
  // types and state
  // -----------------------------------------------------------
  typedef enum logic [1:0] {KEY_IDLE, KEY_GOT_FIRST, KEY_ARMED} key_state_e;

  typedef struct packed {
    logic [NUM_IN-1:0][4:0] in_sel;
    logic [NUM_PINS-1:0][4:0] out_sel;
    logic [NUM_IN-1:0][4:0] in_shadow;
    logic [NUM_PINS-1:0][4:0] out_shadow;
    logic lock;
    logic ever_locked;
    key_state_e key_state;
    logic mismatch;
    logic [NUM_IN-1:0] periph_in;
    logic [NUM_PINS-1:0] pin_out;
    logic [NUM_PINS-1:0] pin_oe;
  } state_s;

  // registered state, its next value and the write qualifiers
  state_s st;
  state_s next_st;
  logic rst_meta;
  logic rst_sync_n;
  logic any_wr;
  logic sel_wr_ok;
  logic lock_wr_ok;

  // -----------------------------------------------------------
  // reset release synchroniser
  // -----------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // pin value for a select code; codes past the last pin read zero
  function automatic logic pick_pin(input logic [4:0] sel, input logic [NUM_PINS-1:0] pins);
    logic v;
    v = 1'b0;
    if (sel <= MAX_PIN_SEL) begin
      v = pins[sel];
    end
    return v;
  endfunction

  // output function lookup; unassigned codes drive nothing
  function automatic logic func_valid(input logic [4:0] code);
    logic v;
    v = 1'b0;
    case (code)
      FN_CMP1, FN_CMP2, FN_SER_TX, FN_SER_DT, FN_SPI_DO, FN_SPI_CK, FN_SPI_DMA_SEL, FN_WAKE: v = 1'b1;
      default: v = (code >= FN_PWM1_A) && (code <= FN_PWM2_D); // pwm channel codes
    endcase
    return v;
  endfunction

  // any write strobe; a stray one aborts the key sequence
  assign any_wr = in_sel_wr_i | out_sel_wr_i | key_wr_i | ctrl_wr_i;
  assign sel_wr_ok = !st.lock;
  // fuse with lock already set blocks change
  assign lock_wr_ok = (st.key_state == KEY_ARMED) && ctrl_wr_i &&
                      !(one_way_lock_fuse_i && st.ever_locked && st.lock);

  // -----------------------------------------------------------
  // next state
  // -----------------------------------------------------------
  always_comb begin
    // hold everything unless a write or a route changes it
    next_st = st;
    case (st.key_state)
      KEY_IDLE: begin
        if (key_wr_i && key_wdata_i == KEY_FIRST) begin
          next_st.key_state = KEY_GOT_FIRST;
        end
      end
      KEY_GOT_FIRST: begin
        if (key_wr_i && key_wdata_i == KEY_SECOND) begin
          next_st.key_state = KEY_ARMED;
        end else if (any_wr) begin
          next_st.key_state = (key_wr_i && key_wdata_i == KEY_FIRST) ? KEY_GOT_FIRST : KEY_IDLE;
        end
      end
      KEY_ARMED: begin
        if (any_wr) begin
          next_st.key_state = (key_wr_i && key_wdata_i == KEY_FIRST) ? KEY_GOT_FIRST : KEY_IDLE;
        end
      end
      default: next_st.key_state = KEY_IDLE;
    endcase
    if (lock_wr_ok) begin
      next_st.lock = ctrl_wdata_i[LOCK_BIT_POS];
      // fuse set permits only the first session
      if (ctrl_wdata_i[LOCK_BIT_POS]) begin
        next_st.ever_locked = 1'b1;
      end
    end
    if (one_way_lock_fuse_i && st.ever_locked) begin
      next_st.lock = 1'b1;
    end
    if (in_sel_wr_i && sel_wr_ok && int'(in_sel_idx_i) < NUM_IN) begin
      next_st.in_sel[in_sel_idx_i] = sel_wdata_i;
      next_st.in_shadow[in_sel_idx_i] = sel_wdata_i;
    end
    // output select write; independent of inputs
    if (out_sel_wr_i && sel_wr_ok && int'(out_sel_idx_i) < NUM_PINS) begin
      next_st.out_sel[out_sel_idx_i] = sel_wdata_i;
      next_st.out_shadow[out_sel_idx_i] = sel_wdata_i;
    end
    if ((st.in_sel != st.in_shadow) || (st.out_sel != st.out_shadow)) begin
      next_st.mismatch = 1'b1;
    end
    // each input picks one pin, a pin may feed many
    for (int i = 0; i < NUM_IN; i++) begin
      next_st.periph_in[i] = pick_pin(st.in_sel[i], pin_in_i);
    end
    // one function per pin, no contention; null disconnects
    for (int p = 0; p < NUM_PINS; p++) begin
      next_st.pin_oe[p] = func_valid(st.out_sel[p]);
      next_st.pin_out[p] = func_valid(st.out_sel[p]) ? func_out_i[st.out_sel[p]] : 1'b0;
    end
  end

  // -----------------------------------------------------------
  // state register
  // -----------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      // inputs reset to pin 31; outputs null
      st.in_sel <= {NUM_IN{IN_SEL_RST}};
      st.in_shadow <= {NUM_IN{IN_SEL_RST}};
      st.out_sel <= {NUM_PINS{OUT_NULL}};
      st.out_shadow <= {NUM_PINS{OUT_NULL}};
      st.lock <= 1'b0;
      st.ever_locked <= 1'b0;
      // key tracker idle, no mismatch pending
      st.key_state <= KEY_IDLE;
      st.mismatch <= 1'b0;
      // routed outputs start quiet
      st.periph_in <= '0;
      st.pin_out <= '0;
      st.pin_oe <= '0;
    end else begin
      st <= next_st;
    end
  end

  // -----------------------------------------------------------
  // outputs
  // -----------------------------------------------------------
  // outputs straight from the state register
  assign periph_in_o = st.periph_in;
  assign pin_out_o = st.pin_out;
  assign pin_oe_o = st.pin_oe;
  assign map_lock_bit_o = st.lock;
  assign pin_select_control_o = {7'h00, st.lock};
  assign mismatch_reset_o = st.mismatch;

  // -----------------------------------------------------------
  // checks
  // -----------------------------------------------------------
  // first key write, then one quiet cycle
  sequence key_first_s;
    (key_wr_i && (key_wdata_i == KEY_FIRST)) ##1 !any_wr;
  endsequence

  // second key write, then one quiet cycle
  sequence key_second_s;
    (key_wr_i && (key_wdata_i == KEY_SECOND)) ##1 !any_wr;
  endsequence

  // both keys with nothing else written in between
  sequence key_pair_s;
    key_first_s ##1 key_second_s;
  endsequence

  chk_key_opens_lock: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_n)
    key_pair_s ##1 (ctrl_wr_i && !one_way_lock_fuse_i) |=> map_lock_bit_o == $past(ctrl_wdata_i[LOCK_BIT_POS]))
    else $error("lock not updated after key");
  chk_no_key_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_n)
    (st.key_state != KEY_ARMED) |=> map_lock_bit_o == $past(map_lock_bit_o) || (one_way_lock_fuse_i && st.ever_locked))
    else $error("lock changed without key");
  chk_locked_in_sel: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_n)
    (st.lock && in_sel_wr_i) |=> $stable(st.in_sel))
    else $error("input select written while locked");
  chk_locked_out_sel: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_n)
    (st.lock && out_sel_wr_i) |=> $stable(st.out_sel))
    else $error("output select written while locked");
  chk_fuse_sticky: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_n)
    (one_way_lock_fuse_i && st.ever_locked && map_lock_bit_o) |=> map_lock_bit_o)
    else $error("one-way lock cleared");
  chk_null_no_drive: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_n)
    (st.out_sel[0] == OUT_NULL) |=> !pin_oe_o[0])
    else $error("null code drives pin");
  chk_in_route: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_n)
    (st.in_sel[0] <= MAX_PIN_SEL) |=> periph_in_o[0] == $past(pin_in_i[st.in_sel[0]]))
    else $error("input routing wrong");
  chk_unlock_write: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_n)
    (!st.lock && in_sel_wr_i && in_sel_idx_i == 4'h0) |=> st.in_sel[0] == $past(sel_wdata_i))
    else $error("unlocked write lost");
  chk_key_sets_lock: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_n)
    key_pair_s ##1 (ctrl_wr_i && ctrl_wdata_i[LOCK_BIT_POS]) |=> map_lock_bit_o)
    else $error("keyed lock set lost");
  chk_key_abort: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_n)
    key_first_s ##1 (any_wr && !key_wr_i) |=> st.key_state == KEY_IDLE)
    else $error("key sequence not aborted");
  chk_fuse_forced: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_n)
    (one_way_lock_fuse_i && st.ever_locked) |=> map_lock_bit_o)
    else $error("fused lock not held");
  chk_shadow_quiet: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_n)
    ((st.in_sel == st.in_shadow) && (st.out_sel == st.out_shadow)) |=>
      mismatch_reset_o == $past(mismatch_reset_o))
    else $error("mismatch flag moved without cause");
  // codes past last pin read zero
  chk_high_sel_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_n)
    (st.in_sel[0] > MAX_PIN_SEL) |=> !periph_in_o[0])
    else $error("unsupported pin code routed");
  chk_null_low_data: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_n)
    (st.out_sel[0] == OUT_NULL) |=> !pin_out_o[0])
    else $error("null code drives data");
  chk_in_untouched: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_n)
    (out_sel_wr_i && !in_sel_wr_i) |=> $stable(st.in_sel))
    else $error("input map moved by output write");
  chk_out_untouched: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_n)
    (in_sel_wr_i && !out_sel_wr_i) |=> $stable(st.out_sel))
    else $error("output map moved by input write");
  chk_ctrl_upper_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_n)
    pin_select_control_o[7:1] == 7'h00)
    else $error("control upper bits set");

  // -----------------------------------------------------------
  // reset values, seen at the first edge out of reset
  // -----------------------------------------------------------
  // lock clear after reset
  chk_reset_lock_clear: assert property (@(posedge sys_clk_i)
    $rose(rst_sync_n) |-> !map_lock_bit_o)
    else $error("lock set after reset");
  chk_reset_sel_codes: assert property (@(posedge sys_clk_i)
    $rose(rst_sync_n) |-> (st.in_sel == {NUM_IN{IN_SEL_RST}}) && (st.out_sel == {NUM_PINS{OUT_NULL}}))
    else $error("select reset codes wrong");

  // -----------------------------------------------------------
  // per-input and per-pin routing checks
  // -----------------------------------------------------------
  for (genvar gi = 0; gi < NUM_IN; gi++) begin : g_in_chk
    // each peripheral input follows its pin
    chk_input_route: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_n)
      (st.in_sel[gi] <= MAX_PIN_SEL) |=> periph_in_o[gi] == $past(pin_in_i[st.in_sel[gi]]))
      else $error("peripheral input routing wrong");
  end

  for (genvar gp = 0; gp < NUM_PINS; gp++) begin : g_pin_chk
    chk_pin_route: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_n)
      func_valid(st.out_sel[gp]) |=> pin_oe_o[gp] && (pin_out_o[gp] == $past(func_out_i[st.out_sel[gp]])))
      else $error("pin output routing wrong");
    chk_pin_idle: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_n)
      !func_valid(st.out_sel[gp]) |=> !pin_oe_o[gp] && !pin_out_o[gp])
      else $error("unused code drives pin");
  end
endmodule

// >>> periph_pin_model.sv
// activity model of the remappable pins and the peripheral outputs
`timescale 1ns/100ps
module periph_pin_model (
  input wire logic sys_clk_i,
  output logic [21:0] pin_level_o,
  output logic [21:0] func_level_o
);
  logic [31:0] st = 32'h1234_5678;
  // new levels every cycle so that a stale route cannot pass
  always @(negedge sys_clk_i) begin
    st <= st * 32'h0019_660D + 32'h3C6E_F35F;
  end
  assign pin_level_o = st[21:0];
  assign func_level_o = st[31:10];
endmodule

// >>> tb.sv
// self-checking bench for the pin remap crossbar
`timescale 1ns/100ps
module tb;
  import pin_remap_pkg::*;
  typedef struct packed {logic lk; logic [14:0][4:0] is; logic [21:0][4:0] os;} note_s;
  logic sys_clk_i = 0, nrst_i = 0, fuse = 0, iw = 0, ow = 0, kw = 0, cw = 0;
  logic [3:0] ii = 0;
  logic [4:0] oi = 0, sd = 0;
  logic [7:0] kd = 0, cd = 0, ctl;
  logic [21:0] pin_in, fn, po, poe, lp, lf;
  logic [14:0] pi;
  logic lk, mm;
  note_s e, q[$];
  int mismatches = 0, n_tests = 0, ks = 0;
  event go;
  // ---------------------------------------------------------
  // clock, far side and design
  // ---------------------------------------------------------
  initial begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  periph_pin_model u_far (.sys_clk_i(sys_clk_i), .pin_level_o(pin_in), .func_level_o(fn));
  remappable_pin_select_lock u_dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .one_way_lock_fuse_i(fuse),
    .in_sel_wr_i(iw), .in_sel_idx_i(ii), .out_sel_wr_i(ow), .out_sel_idx_i(oi), .sel_wdata_i(sd),
    .key_wr_i(kw), .key_wdata_i(kd), .ctrl_wr_i(cw), .ctrl_wdata_i(cd), .pin_in_i(pin_in),
    .func_out_i(fn), .periph_in_o(pi), .pin_out_o(po), .pin_oe_o(poe), .pin_select_control_o(ctl),
    .map_lock_bit_o(lk), .mismatch_reset_o(mm));
  // levels the registered outputs were built from
  always @(posedge sys_clk_i) begin
    lp <= pin_in;
    lf <= fn;
  end
  // ---------------------------------------------------------
  // tasks
  // ---------------------------------------------------------
  function automatic logic oe_code(input logic [4:0] c);
    return c inside {FN_CMP1, FN_CMP2, FN_SER_TX, FN_SER_DT, FN_SPI_DO, FN_SPI_CK, FN_SPI_DMA_SEL, FN_WAKE}
      || (c >= FN_PWM1_A && c <= FN_PWM2_D);
  endfunction
  task automatic cmp(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, x, g);
    end
  endtask
  // one write; k 0 input select, 1 output select, 2 key, 3 control
  task automatic wr(input int k, input int a, input logic [7:0] d);
    @(negedge sys_clk_i);
    {iw, ow, kw, cw} = {k == 0, k == 1, k == 2, k == 3};
    ii = a[3:0];
    oi = a[4:0];
    sd = d[4:0];
    kd = d;
    cd = d;
    @(negedge sys_clk_i);
    {iw, ow, kw, cw} = 4'h0;
    if (k == 3) begin
      if (ks == 2 && !(fuse && e.lk)) e.lk = d[0];
    end else if (!e.lk) begin
      if (k == 0 && a < 15) e.is[a] = d[4:0];
      if (k == 1 && a < 22) e.os[a] = d[4:0];
    end
    ks = (k == 2 && d == KEY_FIRST) ? 1 : (k == 2 && d == KEY_SECOND && ks == 1) ? 2 : 0;
  endtask
  task automatic key_ctl(input logic [7:0] d);
    wr(2, 0, KEY_FIRST);
    wr(2, 0, KEY_SECOND);
    wr(3, 0, d);
  endtask
  task automatic rnd_map();
    for (int i = 0; i < 16; i++) wr(0, i, 8'($urandom_range(31)));
    for (int p = 0; p < 22; p++) wr(1, p, 8'($urandom_range(31)));
  endtask
  task automatic chk();
    repeat (3) @(negedge sys_clk_i);
    q.push_back(e);
    ->go;
  endtask
  task automatic do_reset(input logic f);
    @(negedge sys_clk_i);
    nrst_i = 0;
    fuse = f;
    repeat (16) @(negedge sys_clk_i);
    nrst_i = 1;
    repeat (4) @(negedge sys_clk_i);
    e.lk = 0;
    ks = 0;
    for (int i = 0; i < 15; i++) e.is[i] = IN_SEL_RST;
    for (int p = 0; p < 22; p++) e.os[p] = OUT_NULL;
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ---------------------------------------------------------
  // watcher: oldest note against the outputs
  // ---------------------------------------------------------
  always @(go) begin : watch
    note_s n;
    logic [14:0] xi;
    logic [21:0] xe;
    n = q.pop_front();
    for (int i = 0; i < 15; i++) xi[i] = n.is[i] < 22 ? lp[n.is[i]] : 1'b0;
    for (int p = 0; p < 22; p++) xe[p] = oe_code(n.os[p]);
    cmp("lock", n.lk, lk);
    cmp("control", {7'h00, n.lk}, ctl);
    cmp("periph_in", xi, pi);
    cmp("pin_oe", xe, poe);
    for (int p = 0; p < 22; p++) cmp("pin_out", xe[p] ? lf[n.os[p]] : 1'b0, po[p]);
    cmp("mismatch", 0, mm);
  end
  // watchdog far beyond the expected run
  initial begin
    #400us;
    mismatches++;
    complete_run();
  end
  // ---------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------
  initial begin
    void'($urandom(95386));
    do_reset(1'b0);
    chk();
    for (int p = 0; p < 22; p++) wr(1, p, 8'(p));
    wr(0, 0, 8'h07);
    wr(0, 1, 8'h07);
    chk();
    rnd_map();
    chk();
    key_ctl(8'h01);
    rnd_map();
    chk();
    wr(2, 0, KEY_FIRST);
    wr(0, 2, 8'h04);
    wr(2, 0, KEY_SECOND);
    wr(3, 0, 8'h00);
    wr(3, 0, 8'h00);
    chk();
    key_ctl(8'h00);
    rnd_map();
    key_ctl(8'hFF);
    key_ctl(8'hFE);
    rnd_map();
    chk();
    do_reset(1'b1);
    rnd_map();
    key_ctl(8'h01);
    key_ctl(8'h00);
    rnd_map();
    chk();
    do_reset(1'b1);
    chk();
    rnd_map();
    chk();
    complete_run();
  end
endmodule
